// ==== dv/fcl_loader_monitor.sv ====
// Concurrent checks on the fuse loader ports
`timescale 1ns/1ps
module fcl_monitor (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Watched ports
    input wire logic chip_erase_i,
    input wire logic debug_entry_i,
    input wire logic fault_detect_flag_i,
    input wire logic eeprom_erase_o,
    input wire logic eeprom_preserve_o,
    input wire logic device_locked_o,
    input wire logic compare_force_default_o,
    input wire logic periph_release_o,
    input wire logic crc_scan_start_o,
    input wire logic [1:0] crc_region_select_o,
    input wire logic [1:0] reset_pin_function_o,
    input wire logic gpio_drive_allow_o,
    input wire logic [3:0] wdt_window_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_hold_low;
        !periph_release_o [*8];
    endsequence
    a_release_timing: assert property (
        $rose(nrst_i) |-> s_hold_low ##[4:6] periph_release_o) else $error("release late");
    a_fields_stable: assert property (
        periph_release_o |=> $stable(wdt_window_o)) else $error("field moved");
    a_gpio_fn_zero: assert property (
        gpio_drive_allow_o |-> periph_release_o && reset_pin_function_o == 2'h0)
        else $error("gpio drive wrong");
    a_blank_start: assert property (
        $rose(periph_release_o) |-> !gpio_drive_allow_o [*8]) else $error("no blanking");
    a_force_dflt: assert property (
        debug_entry_i && fault_detect_flag_i |=> compare_force_default_o)
        else $error("default not forced");
    a_crc_start: assert property (
        crc_scan_start_o |-> $rose(periph_release_o) && crc_region_select_o != 2'h3)
        else $error("crc start wrong");
    a_ee_erase: assert property (
        chip_erase_i && periph_release_o && (device_locked_o || !eeprom_preserve_o)
        |=> eeprom_erase_o) else $error("eeprom kept");
    a_ee_keep: assert property (
        chip_erase_i && !device_locked_o && eeprom_preserve_o |=> !eeprom_erase_o)
        else $error("eeprom erased");
endmodule
bind fcl_loader fcl_monitor u_mon (.*);

// ==== dv/fcl_loader_tb.sv ====
// Self-checking bench of the fuse loader
`timescale 1ns/1ps
module fcl_loader_tb;
    logic ref_clk_i, nrst_i, factory_init_i, cpu_rd_i, dbg_rd_i, dbg_wr_i, chip_erase_i;
    logic debug_entry_i, fault_detect_flag_i, slow_32k_oscillator_i, cpu_rvalid_o;
    logic dbg_rvalid_o, brownout_sample_rate_o, osc_cal_lock_o, compare_force_default_o;
    logic crc_scan_start_o, eeprom_preserve_o, device_locked_o, flash_erase_o;
    logic eeprom_erase_o, gpio_drive_allow_o, periph_release_o;
    logic [3:0] cpu_addr_i, dbg_addr_i, wdt_window_o, wdt_period_o, osc_calibration_b_o;
    logic [7:0] dbg_wdata_i, cpu_rdata_o, dbg_rdata_o, timer_fault_control_o;
    logic [2:0] brownout_threshold_o;
    logic [1:0] brownout_active_mode_o, brownout_sleep_mode_o, osc_freq_select_o;
    logic [1:0] crc_region_select_o, reset_pin_function_o;
    logic [6:0] osc_calibration_a_o;
    logic [39:0] v;
    int miscompares = 0;
    int total_checks = 0;
    // Rows: watchdog, brown-out, oscillator, timer, system A fuse bytes
    logic [39:0] rows [4] = '{40'h5a11_81a5_05, 40'hc346_023c_48, 40'h0ff8_01ff_81,
                              40'hf00c_8200_c0};
    fcl_loader #(.BLANK_CYCLES(4)) DUT (.*);
    fcl_prog_model u_prog (.clk_i(ref_clk_i), .wr_o(dbg_wr_i), .addr_o(dbg_addr_i),
                           .wdata_o(dbg_wdata_i), .slow_o(slow_32k_oscillator_i));
    always #5 ref_clk_i = ~ref_clk_i;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic pulse(ref logic p);
        @(posedge ref_clk_i);
        #1 p = 1'b1;
        @(posedge ref_clk_i);
        #1 p = 1'b0;
    endtask
    task automatic rst;
        @(posedge ref_clk_i);
        #1 nrst_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1 nrst_i = 1'b1;
        for (int i = 0; i < 40 && periph_release_o !== 1'b1; i++) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        miscompares++;
        close_out();
    end
    initial begin
        {ref_clk_i, nrst_i, cpu_rd_i, dbg_rd_i, chip_erase_i} = '0;
        {debug_entry_i, fault_detect_flag_i, cpu_addr_i} = '0;
        factory_init_i = 1'b1;
        repeat (16) @(posedge ref_clk_i);
        #1 factory_init_i = 1'b0;
        for (int r = 0; r < 4; r++) begin
            v = rows[r];
            for (int k = 0; k < 5; k++) u_prog.prog(4'(k < 3 ? k : k + 1), v[39-8*k -: 8]);
            rst();
            chk(gpio_drive_allow_o, 1'b0);
            chk(wdt_window_o, v[39:36]);
            chk(wdt_period_o, v[35:32]);
            chk(brownout_threshold_o, v[31:29]);
            chk(brownout_sample_rate_o, v[28]);
            chk(brownout_active_mode_o, v[27:26]);
            chk(brownout_sleep_mode_o, v[25:24]);
            chk(osc_cal_lock_o, v[23]);
            chk(osc_freq_select_o, v[17:16]);
            chk(osc_calibration_a_o, v[17:16] == 2'h1 ? 8'h00 : 8'h7f);
            chk(osc_calibration_b_o, v[17:16] == 2'h1 ? 8'h00 : 8'h0f);
            chk(timer_fault_control_o, v[15:8]);
            chk(crc_region_select_o, v[7:6]);
            chk(reset_pin_function_o, v[3:2]);
            chk(eeprom_preserve_o, v[0]);
            chk(device_locked_o, 1'b0);
            cpu_addr_i = 4'h5;
            pulse(cpu_rd_i);
            chk(cpu_rdata_o, v[7:0] | 8'h32);
            chk(cpu_rvalid_o, 1'b1);
            pulse(chip_erase_i);
            chk(eeprom_erase_o, !v[0]);
            chk(flash_erase_o, 1'b1);
            repeat (100) @(posedge ref_clk_i);
            chk(gpio_drive_allow_o, v[3:2] == 2'h0);
        end
        // Unmapped offset reads as zero
        cpu_addr_i = 4'h3;
        pulse(cpu_rd_i);
        chk(cpu_rdata_o, 8'h00);
        // Locked part erases eeprom even with preserve set
        u_prog.prog(4'ha, 8'h00);
        u_prog.prog(4'h5, 8'h01);
        // Debug read wins a collision, the CPU read follows one cycle later
        cpu_addr_i = 4'h6;
        @(posedge ref_clk_i);
        #1 {dbg_rd_i, cpu_rd_i} = 2'b11;
        @(posedge ref_clk_i);
        #1 {dbg_rd_i, cpu_rd_i} = 2'b00;
        chk(dbg_rdata_o, 8'h33);
        chk(dbg_rvalid_o, 1'b1);
        chk(cpu_rvalid_o, 1'b0);
        @(posedge ref_clk_i);
        #1 chk(cpu_rdata_o, 8'h07);
        chk(cpu_rvalid_o, 1'b1);
        rst();
        u_prog.prog(4'h0, 8'h33);
        chk(wdt_window_o, 4'hf);
        pulse(chip_erase_i);
        chk(eeprom_erase_o, 1'b1);
        chk(device_locked_o, 1'b1);
        @(posedge ref_clk_i);
        #1 {debug_entry_i, fault_detect_flag_i} = 2'b11;
        @(posedge ref_clk_i);
        #1 chk(compare_force_default_o, 1'b1);
        {debug_entry_i, fault_detect_flag_i} = 2'b00;
        close_out();
    end
endmodule

// ==== dv/fcl_prog_model.sv ====
// Debug-port fuse programmer and free-running slow oscillator
`timescale 1ns/1ps
module fcl_prog_model (
    // Clock
    input wire logic clk_i,
    // Fuse programming
    output logic wr_o,
    output logic [3:0] addr_o,
    output logic [7:0] wdata_o,
    // Slow oscillator, 80 ns period so each level spans four system cycles
    output logic slow_o
);
    initial begin
        {wr_o, addr_o, wdata_o, slow_o} = '0;
    end
    always #40 slow_o = ~slow_o;
    function automatic logic [7:0] rsv(input logic [3:0] a);
        case (a)
            4'h2: rsv = 8'h7c;
            4'h5: rsv = 8'h32;
            4'h6: rsv = 8'hf8;
            default: rsv = 8'h00;
        endcase
    endfunction
    task automatic prog(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d | rsv(a);
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask
endmodule

// ==== rtl/fcl_blank_timer.sv ====
// Counts slow oscillator edges after a start pulse and flags expiry
`timescale 1ns/1ps
module fcl_blank_timer #(
    parameter int CYCLES = fcl_pkg::FCL_BLANK_SLOW_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Control
    input wire logic slow_clk_i,
    input wire logic start_i,
    output logic expired_o
);
    import fcl_pkg::*;

    localparam logic [FCL_BLANK_W-1:0] LAST = FCL_BLANK_W'(CYCLES - 1);

    logic [2:0] sync_ff, nxt_sync;
    logic stable_ff, nxt_stable;
    logic run_ff, nxt_run;
    logic done_ff, nxt_done;
    logic [FCL_BLANK_W-1:0] cnt_ff, nxt_cnt;
    logic rise;

    // A level counts only once the last two stages agree
    always_comb begin
        nxt_sync = {sync_ff[1:0], slow_clk_i};
        nxt_stable = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : stable_ff;
        rise = nxt_stable && !stable_ff;
        nxt_run = run_ff;
        nxt_done = done_ff;
        nxt_cnt = cnt_ff;
        if (start_i) begin
            nxt_run = 1'b1;
            nxt_done = 1'b0;
            nxt_cnt = '0;
        end else if (run_ff && rise) begin
            if (cnt_ff == LAST) begin
                nxt_run = 1'b0;
                nxt_done = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sync_ff <= 3'h0;
            stable_ff <= 1'b0;
            run_ff <= 1'b0;
            done_ff <= 1'b0;
            cnt_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
            stable_ff <= nxt_stable;
            run_ff <= nxt_run;
            done_ff <= nxt_done;
            cnt_ff <= nxt_cnt;
        end
    end

    assign expired_o = done_ff;
endmodule

// ==== rtl/fcl_fuse_if.sv ====
// Carrier between the loader and its fuse storage
`timescale 1ns/1ps
interface fcl_fuse_if;
    logic [3:0] ld_idx;
    logic [7:0] ld_data;
    logic [3:0] bus_idx;
    logic [7:0] bus_data;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic factory_init;
    modport ctrl (output ld_idx, bus_idx, wr_en, wr_idx, wr_data, factory_init,
                  input ld_data, bus_data);
    modport store (input ld_idx, bus_idx, wr_en, wr_idx, wr_data, factory_init,
                   output ld_data, bus_data);
endinterface

// ==== rtl/fcl_fuse_store.sv ====
// Nonvolatile fuse bytes held in flip-flops, two read ports, one write port
`timescale 1ns/1ps
module fcl_fuse_store (
    // Clock
    input wire logic ref_clk_i,
    // Fuse access
    fcl_fuse_if.store fuse
);
    import fcl_pkg::*;

    logic [7:0] mem_ff [FCL_NUM_FUSES];
    logic [7:0] nxt_mem [FCL_NUM_FUSES];

    function automatic logic [7:0] fuse_rd(input logic [3:0] idx,
                                           input logic [7:0] m [FCL_NUM_FUSES]);
        fuse_rd = 8'h00;
        if (idx <= FCL_OFS_LAST && idx != FCL_OFS_RSVD_A && idx != FCL_OFS_RSVD_B) begin
            fuse_rd = m[idx];
        end
    endfunction

    assign fuse.ld_data = fuse_rd(fuse.ld_idx, mem_ff);
    assign fuse.bus_data = fuse_rd(fuse.bus_idx, mem_ff);

    // ---------------------------------------------------------------
    // Storage is not cleared by system reset: it models nonvolatile cells
    // ---------------------------------------------------------------
    always_comb begin
        nxt_mem = mem_ff;
        if (fuse.factory_init) begin
            nxt_mem[FCL_OFS_WATCHDOG] = FCL_FACT_WATCHDOG;
            nxt_mem[FCL_OFS_BROWNOUT] = FCL_FACT_BROWNOUT;
            nxt_mem[FCL_OFS_OSC] = FCL_FACT_OSC;
            nxt_mem[FCL_OFS_RSVD_A] = FCL_FACT_RSVD;
            nxt_mem[FCL_OFS_TIMER_CMP] = FCL_FACT_TIMER_CMP;
            nxt_mem[FCL_OFS_SYS_A] = FCL_FACT_SYS_A;
            nxt_mem[FCL_OFS_SYS_B] = FCL_FACT_SYS_B;
            nxt_mem[FCL_OFS_APP_END] = FCL_FACT_APP_END;
            nxt_mem[FCL_OFS_BOOT_END] = FCL_FACT_BOOT_END;
            nxt_mem[FCL_OFS_RSVD_B] = FCL_FACT_RSVD;
            nxt_mem[FCL_OFS_LOCK_KEY] = FCL_FACT_LOCK_KEY;
        end else if (fuse.wr_en && fuse.wr_idx <= FCL_OFS_LAST) begin
            nxt_mem[fuse.wr_idx] = fuse.wr_data;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        mem_ff <= nxt_mem;
    end
endmodule

// ==== rtl/fcl_loader.sv ====
// Fuse configuration loader: copies fuse bytes to peripheral fields at reset
`timescale 1ns/1ps
module fcl_loader #(
    parameter int CAL_A_W = 7,
    parameter int CAL_B_W = 4,
    parameter logic [CAL_A_W-1:0] CAL16_A = '0,
    parameter logic [CAL_B_W-1:0] CAL16_B = '0,
    parameter logic [CAL_A_W-1:0] CAL20_A = '1,
    parameter logic [CAL_B_W-1:0] CAL20_B = '1,
    parameter int BLANK_CYCLES = fcl_pkg::FCL_BLANK_SLOW_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Fuse array initialisation at manufacture
    input wire logic factory_init_i,
    // CPU read port
    input wire logic cpu_rd_i,
    input wire logic [fcl_pkg::FCL_AW-1:0] cpu_addr_i,
    output logic [7:0] cpu_rdata_o,
    output logic cpu_rvalid_o,
    // Debug port read and program
    input wire logic dbg_rd_i,
    input wire logic dbg_wr_i,
    input wire logic [fcl_pkg::FCL_AW-1:0] dbg_addr_i,
    input wire logic [7:0] dbg_wdata_i,
    output logic [7:0] dbg_rdata_o,
    output logic dbg_rvalid_o,
    input wire logic chip_erase_i,
    // Watchdog control fields
    output logic [3:0] wdt_window_o,
    output logic [3:0] wdt_period_o,
    // Brown-out control fields
    output logic [2:0] brownout_threshold_o,
    output logic brownout_sample_rate_o,
    output logic [1:0] brownout_active_mode_o,
    output logic [1:0] brownout_sleep_mode_o,
    // Main RC oscillator fields
    output logic osc_cal_lock_o,
    output logic [1:0] osc_freq_select_o,
    output logic [CAL_A_W-1:0] osc_calibration_a_o,
    output logic [CAL_B_W-1:0] osc_calibration_b_o,
    // Timer fault control fields
    input wire logic debug_entry_i,
    input wire logic fault_detect_flag_i,
    output logic [7:0] timer_fault_control_o,
    output logic compare_force_default_o,
    // System options
    output logic [1:0] crc_region_select_o,
    output logic crc_scan_start_o,
    output logic [1:0] reset_pin_function_o,
    output logic eeprom_preserve_o,
    output logic device_locked_o,
    output logic flash_erase_o,
    output logic eeprom_erase_o,
    // Reset pin output blanking
    input wire logic slow_32k_oscillator_i,
    output logic gpio_drive_allow_o,
    // Start-up status
    output logic periph_release_o
);
    import fcl_pkg::*;

    fcl_fuse_if fuse ();

    // ---------------------------------------------------------------
    // Storage and blanking timer
    // ---------------------------------------------------------------
    fcl_fuse_store u_store (
        .ref_clk_i(ref_clk_i),
        .fuse(fuse.store)
    );

    logic blank_start_ff, nxt_blank_start;
    logic blank_expired;

    fcl_blank_timer #(
        .CYCLES(BLANK_CYCLES)
    ) u_blank (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .slow_clk_i(slow_32k_oscillator_i),
        .start_i(blank_start_ff),
        .expired_o(blank_expired)
    );

    // ---------------------------------------------------------------
    // Start-up walk over the fuse bytes
    // ---------------------------------------------------------------
    fcl_state_e state_ff, nxt_state;
    logic [3:0] idx_ff, nxt_idx;
    logic release_ff, nxt_release;
    logic crc_start_ff, nxt_crc_start;
    logic [1:0] crc_ff, nxt_crc;

    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_release = release_ff;
        nxt_crc_start = 1'b0;
        nxt_blank_start = 1'b0;
        case (state_ff)
            FCL_ST_IDLE: begin
                nxt_state = FCL_ST_LOAD;
                nxt_idx = FCL_OFS_WATCHDOG;
            end
            FCL_ST_LOAD: begin
                if (idx_ff == FCL_OFS_LAST) begin
                    // Peripherals see final values by release; the lock key lands in the same cycle
                    nxt_state = FCL_ST_DONE;
                    nxt_release = 1'b1;
                    nxt_blank_start = 1'b1;
                    nxt_crc_start = (crc_ff != FCL_CRC_NONE);
                end else begin
                    nxt_idx = idx_ff + 4'h1;
                end
            end
            FCL_ST_DONE: begin
                // Only a reset restarts the walk, so new fuses wait for it
                nxt_state = FCL_ST_DONE;
            end
            default: begin
                nxt_state = FCL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_ff <= FCL_ST_IDLE;
            idx_ff <= 4'h0;
            release_ff <= 1'b0;
            crc_start_ff <= 1'b0;
            blank_start_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            release_ff <= nxt_release;
            crc_start_ff <= nxt_crc_start;
            blank_start_ff <= nxt_blank_start;
        end
    end

    assign fuse.ld_idx = idx_ff;

    // ---------------------------------------------------------------
    // Target fields
    // ---------------------------------------------------------------
    logic [7:0] wdt_ff, nxt_wdt;
    logic [7:0] bod_ff, nxt_bod;
    logic lock_ff, nxt_lock;
    logic [1:0] freq_ff, nxt_freq;
    logic [CAL_A_W-1:0] cal_a_ff, nxt_cal_a;
    logic [CAL_B_W-1:0] cal_b_ff, nxt_cal_b;
    logic [7:0] tmr_ff, nxt_tmr;
    logic [1:0] pin_ff, nxt_pin;
    logic keep_ee_ff, nxt_keep_ee;
    logic locked_ff, nxt_locked;
    logic [7:0] d;

    always_comb begin
        d = fuse.ld_data;
        nxt_wdt = wdt_ff;
        nxt_bod = bod_ff;
        nxt_lock = lock_ff;
        nxt_freq = freq_ff;
        nxt_cal_a = cal_a_ff;
        nxt_cal_b = cal_b_ff;
        nxt_tmr = tmr_ff;
        nxt_crc = crc_ff;
        nxt_pin = pin_ff;
        nxt_keep_ee = keep_ee_ff;
        nxt_locked = locked_ff;
        if (state_ff == FCL_ST_LOAD) begin
            case (idx_ff)
                FCL_OFS_WATCHDOG: begin
                    nxt_wdt = d;
                end
                FCL_OFS_BROWNOUT: begin
                    nxt_bod = d;
                end
                FCL_OFS_OSC: begin
                    nxt_lock = d[FCL_OSC_LOCK];
                    nxt_freq = d[FCL_OSC_FREQ_HI:FCL_OSC_FREQ_LO];
                    // Reserved codes fall back to the 20 MHz trim
                    if (d[FCL_OSC_FREQ_HI:FCL_OSC_FREQ_LO] == FCL_FREQ_16M) begin
                        nxt_cal_a = CAL16_A;
                        nxt_cal_b = CAL16_B;
                    end else begin
                        nxt_cal_a = CAL20_A;
                        nxt_cal_b = CAL20_B;
                    end
                end
                FCL_OFS_TIMER_CMP: begin
                    nxt_tmr = d;
                end
                FCL_OFS_SYS_A: begin
                    nxt_crc = d[FCL_CRC_HI:FCL_CRC_LO];
                    nxt_pin = d[FCL_PIN_HI:FCL_PIN_LO];
                    nxt_keep_ee = d[FCL_EE_KEEP];
                end
                FCL_OFS_LOCK_KEY: begin
                    nxt_locked = (d != FCL_UNLOCK_KEY);
                end
                default: begin
                    nxt_wdt = wdt_ff;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            wdt_ff <= 8'h00;
            bod_ff <= 8'h00;
            lock_ff <= 1'b0;
            freq_ff <= 2'h0;
            cal_a_ff <= '0;
            cal_b_ff <= '0;
            tmr_ff <= 8'h00;
            crc_ff <= 2'h0;
            pin_ff <= 2'h0;
            keep_ee_ff <= 1'b0;
            locked_ff <= 1'b1;
        end else begin
            wdt_ff <= nxt_wdt;
            bod_ff <= nxt_bod;
            lock_ff <= nxt_lock;
            freq_ff <= nxt_freq;
            cal_a_ff <= nxt_cal_a;
            cal_b_ff <= nxt_cal_b;
            tmr_ff <= nxt_tmr;
            crc_ff <= nxt_crc;
            pin_ff <= nxt_pin;
            keep_ee_ff <= nxt_keep_ee;
            locked_ff <= nxt_locked;
        end
    end

    // ---------------------------------------------------------------
    // Fuse access ports, debug takes the read port when both ask
    // ---------------------------------------------------------------
    logic [7:0] cpu_rdata_ff, nxt_cpu_rdata;
    logic cpu_rvalid_ff, nxt_cpu_rvalid;
    logic [7:0] dbg_rdata_ff, nxt_dbg_rdata;
    logic dbg_rvalid_ff, nxt_dbg_rvalid;
    logic cpu_wait_ff, nxt_cpu_wait;
    logic [3:0] cpu_addr_ff, nxt_cpu_addr;

    always_comb begin
        nxt_cpu_wait = cpu_wait_ff;
        nxt_cpu_addr = cpu_addr_ff;
        if (cpu_rd_i) begin
            nxt_cpu_addr = cpu_addr_i;
        end
        fuse.bus_idx = dbg_rd_i ? dbg_addr_i : (cpu_rd_i ? cpu_addr_i : cpu_addr_ff);
        nxt_dbg_rvalid = dbg_rd_i;
        nxt_dbg_rdata = dbg_rd_i ? fuse.bus_data : 8'h00;
        // A CPU read that loses to the debug port is held until a cycle with no debug read
        nxt_cpu_rvalid = !dbg_rd_i && (cpu_rd_i || cpu_wait_ff);
        nxt_cpu_rdata = nxt_cpu_rvalid ? fuse.bus_data : 8'h00;
        nxt_cpu_wait = dbg_rd_i && (cpu_rd_i || cpu_wait_ff);
        // The CPU has no write path into the array
        fuse.wr_en = dbg_wr_i;
        fuse.wr_idx = dbg_addr_i;
        fuse.wr_data = dbg_wdata_i;
        fuse.factory_init = factory_init_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cpu_rdata_ff <= 8'h00;
            cpu_rvalid_ff <= 1'b0;
            dbg_rdata_ff <= 8'h00;
            dbg_rvalid_ff <= 1'b0;
            cpu_wait_ff <= 1'b0;
            cpu_addr_ff <= 4'h0;
        end else begin
            cpu_rdata_ff <= nxt_cpu_rdata;
            cpu_rvalid_ff <= nxt_cpu_rvalid;
            dbg_rdata_ff <= nxt_dbg_rdata;
            dbg_rvalid_ff <= nxt_dbg_rvalid;
            cpu_wait_ff <= nxt_cpu_wait;
            cpu_addr_ff <= nxt_cpu_addr;
        end
    end

    // ---------------------------------------------------------------
    // Chip erase, debug entry and pin blanking
    // ---------------------------------------------------------------
    logic flash_erase_ff, nxt_flash_erase;
    logic ee_erase_ff, nxt_ee_erase;
    logic force_ff, nxt_force;
    logic drive_ff, nxt_drive;

    always_comb begin
        nxt_flash_erase = chip_erase_i;
        // Lock overrides the preserve option
        nxt_ee_erase = chip_erase_i && (!keep_ee_ff || locked_ff);
        nxt_force = debug_entry_i && fault_detect_flag_i;
        // Driver stays off until the slow-clock blanking has run out
        nxt_drive = release_ff && (pin_ff == FCL_PIN_GPIO) && blank_expired;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            flash_erase_ff <= 1'b0;
            ee_erase_ff <= 1'b0;
            force_ff <= 1'b0;
            drive_ff <= 1'b0;
        end else begin
            flash_erase_ff <= nxt_flash_erase;
            ee_erase_ff <= nxt_ee_erase;
            force_ff <= nxt_force;
            drive_ff <= nxt_drive;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign cpu_rdata_o = cpu_rdata_ff;
    assign cpu_rvalid_o = cpu_rvalid_ff;
    assign dbg_rdata_o = dbg_rdata_ff;
    assign dbg_rvalid_o = dbg_rvalid_ff;
    assign wdt_window_o = wdt_ff[FCL_WDT_WIN_HI:FCL_WDT_WIN_LO];
    assign wdt_period_o = wdt_ff[FCL_WDT_PER_HI:FCL_WDT_PER_LO];
    assign brownout_threshold_o = bod_ff[FCL_BOD_LVL_HI:FCL_BOD_LVL_LO];
    assign brownout_sample_rate_o = bod_ff[FCL_BOD_SAMP];
    assign brownout_active_mode_o = bod_ff[FCL_BOD_ACT_HI:FCL_BOD_ACT_LO];
    assign brownout_sleep_mode_o = bod_ff[FCL_BOD_SLP_HI:FCL_BOD_SLP_LO];
    assign osc_cal_lock_o = lock_ff;
    assign osc_freq_select_o = freq_ff;
    assign osc_calibration_a_o = cal_a_ff;
    assign osc_calibration_b_o = cal_b_ff;
    assign timer_fault_control_o = tmr_ff;
    assign compare_force_default_o = force_ff;
    assign crc_region_select_o = crc_ff;
    assign crc_scan_start_o = crc_start_ff;
    assign reset_pin_function_o = pin_ff;
    assign eeprom_preserve_o = keep_ee_ff;
    assign device_locked_o = locked_ff;
    assign flash_erase_o = flash_erase_ff;
    assign eeprom_erase_o = ee_erase_ff;
    assign gpio_drive_allow_o = drive_ff;
    assign periph_release_o = release_ff;
endmodule

// ==== rtl/fcl_pkg.sv ====
// Shared constants and types of the fuse configuration loader
package fcl_pkg;
    // ---------------------------------------------------------------
    // Fuse array layout
    // ---------------------------------------------------------------
    localparam int FCL_AW = 4;
    localparam int FCL_NUM_FUSES = 11;
    localparam logic [3:0] FCL_OFS_WATCHDOG = 4'h0;
    localparam logic [3:0] FCL_OFS_BROWNOUT = 4'h1;
    localparam logic [3:0] FCL_OFS_OSC = 4'h2;
    localparam logic [3:0] FCL_OFS_RSVD_A = 4'h3;
    localparam logic [3:0] FCL_OFS_TIMER_CMP = 4'h4;
    localparam logic [3:0] FCL_OFS_SYS_A = 4'h5;
    localparam logic [3:0] FCL_OFS_SYS_B = 4'h6;
    localparam logic [3:0] FCL_OFS_APP_END = 4'h7;
    localparam logic [3:0] FCL_OFS_BOOT_END = 4'h8;
    localparam logic [3:0] FCL_OFS_RSVD_B = 4'h9;
    localparam logic [3:0] FCL_OFS_LOCK_KEY = 4'ha;
    localparam logic [3:0] FCL_OFS_LAST = 4'ha;
    // ---------------------------------------------------------------
    // Factory-programmed contents, loaded by factory_init_i
    // ---------------------------------------------------------------
    localparam logic [7:0] FCL_FACT_WATCHDOG = 8'h00;
    localparam logic [7:0] FCL_FACT_BROWNOUT = 8'h00;
    localparam logic [7:0] FCL_FACT_OSC = 8'h02;
    localparam logic [7:0] FCL_FACT_TIMER_CMP = 8'h00;
    localparam logic [7:0] FCL_FACT_SYS_A = 8'hf6;
    localparam logic [7:0] FCL_FACT_SYS_B = 8'h07;
    localparam logic [7:0] FCL_FACT_APP_END = 8'h00;
    localparam logic [7:0] FCL_FACT_BOOT_END = 8'h00;
    localparam logic [7:0] FCL_FACT_LOCK_KEY = 8'hc5;
    localparam logic [7:0] FCL_FACT_RSVD = 8'hff;
    localparam logic [7:0] FCL_UNLOCK_KEY = 8'hc5;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int FCL_WDT_WIN_HI = 7;
    localparam int FCL_WDT_WIN_LO = 4;
    localparam int FCL_WDT_PER_HI = 3;
    localparam int FCL_WDT_PER_LO = 0;
    localparam int FCL_BOD_LVL_HI = 7;
    localparam int FCL_BOD_LVL_LO = 5;
    localparam int FCL_BOD_SAMP = 4;
    localparam int FCL_BOD_ACT_HI = 3;
    localparam int FCL_BOD_ACT_LO = 2;
    localparam int FCL_BOD_SLP_HI = 1;
    localparam int FCL_BOD_SLP_LO = 0;
    localparam int FCL_OSC_LOCK = 7;
    localparam int FCL_OSC_FREQ_HI = 1;
    localparam int FCL_OSC_FREQ_LO = 0;
    localparam int FCL_CMP_EN_HI = 7;
    localparam int FCL_CMP_EN_LO = 4;
    localparam int FCL_CMP_LVL_HI = 3;
    localparam int FCL_CMP_LVL_LO = 0;
    localparam int FCL_CRC_HI = 7;
    localparam int FCL_CRC_LO = 6;
    localparam int FCL_PIN_HI = 3;
    localparam int FCL_PIN_LO = 2;
    localparam int FCL_EE_KEEP = 0;
    // ---------------------------------------------------------------
    // Encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] FCL_FREQ_16M = 2'h1;
    localparam logic [1:0] FCL_FREQ_20M = 2'h2;
    localparam logic [1:0] FCL_CRC_NONE = 2'h3;
    localparam logic [1:0] FCL_PIN_GPIO = 2'h0;
    // ---------------------------------------------------------------
    // Timing: output blanking in slow oscillator cycles
    // ---------------------------------------------------------------
    localparam int FCL_BLANK_SLOW_CYCLES = 768;
    localparam int FCL_BLANK_W = 10;

    typedef enum logic [1:0] {
        FCL_ST_IDLE = 2'b00,
        FCL_ST_LOAD = 2'b01,
        FCL_ST_DONE = 2'b10
    } fcl_state_e;
endpackage
